// [src/comparator_output_and_reference_ctrl.sv]
// Purpose: comparator output routing, change flags and reference control
// Assumes: comparator results are asynchronous analog outputs
// Notes:   timer clock is sampled as an input, no second clock domain
//
// Summary of operation
// - enabled pin output carries raw comparator result
// - pin direction bit still gates the driver
// - gate source picks pin or comparator 2
// - select bit one: one means gate pin
// - sync bit latches comparator 2 on timer fall
// - timer counts on rising edge, opposite capture
// - result change sets its change flag
// - flag clears by writing zero, one sets
// - request needs own, peripheral and global enable
// - flag set on mismatch edge, not level
// - return to old state flags only after refresh
// - mirror read leaves mismatch store untouched
// - change during control read may be missed
// - reset restores every register value
// - mirror register shows both results at once
// - ladder has 16 levels per range, two ranges
// - ladder powered down when all users clear
// - bandgap stable flag reads at bit five
// - bypass bit unpowers buffer, unbuffered pin
// - fixed reference enable powers the bandgap
// - ladder pin bit overrides fixed reference pin bit
`timescale 1ns/1ps
`default_nettype none
`include "cmp_ref_regs.svh"

module comparator_output_and_reference_ctrl
  import cmp_ref_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // axi4-lite write address and data
  input  wire logic [7:0]      awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  // axi4-lite write response
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  // axi4-lite read
  input  wire logic [7:0]      araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  // analog comparator results, asynchronous
  input  wire logic            cmp1Raw,
  input  wire logic            cmp2Raw,
  input  wire logic            bandgapReady,
  // port direction bits of the two output pins, one keeps pin undriven
  input  wire logic            cmp1PinDirection,
  input  wire logic            cmp2PinDirection,
  // timer clock after prescaler, and external gate pin
  input  wire logic            timerClockIn,
  input  wire logic            timerGatePin,
  // outputs
  output pin_drive_type        cmp1Pin,
  output pin_drive_type        cmp2Pin,
  output logic                 timerGate,
  output logic                 timerCountEnable,
  output logic [1:0]           cmpIrq,
  output analog_ctrl_type      analogCtrl
);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0]    cmp1Ctrl;
  logic [7:0]    cmp2Ctrl;
  logic [1:0]    gateCtrl;
  logic [7:0]    ladderCtrl;
  logic [7:0]    bandgapCtrl;
  logic [1:0]    changeFlag;
  logic [7:0]    irqEnable;
  bus_state_type busState;
  logic          awTaken;
  logic          wTaken;
  logic [7:0]    awLatch;
  logic [7:0]    wLatch;
  logic          wLaneOk;

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic [2:0]    sync1;
  logic [2:0]    sync2;
  logic [2:0]    syncBg;
  logic [2:0]    syncTclk;
  logic [2:0]    syncGate;
  logic [1:0]    result;
  logic          bgStable;
  logic          tclkLevel;
  logic          gatePinLevel;
  logic          tclkPrev;
  logic [1:0]    mismatch;
  logic          cmp2Latched;

  // three stages; a change counts once stage two and three agree
  // result synchroniser chain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1    <= 3'h0;
      sync2    <= 3'h0;
      syncBg   <= 3'h0;
      syncTclk <= 3'h0;
      syncGate <= 3'h0;
    end else begin
      sync1    <= {sync1[1:0], cmp1Raw};
      sync2    <= {sync2[1:0], cmp2Raw};
      syncBg   <= {syncBg[1:0], bandgapReady};
      syncTclk <= {syncTclk[1:0], timerClockIn};
      syncGate <= {syncGate[1:0], timerGatePin};
    end
  end

  // filtered levels, held while stages disagree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result       <= 2'h0;
      bgStable     <= 1'b0;
      tclkLevel    <= 1'b0;
      gatePinLevel <= 1'b0;
    end else begin
      if (sync1[1] == sync1[2]) result[0] <= sync1[2];
      if (sync2[1] == sync2[2]) result[1] <= sync2[2];
      if (syncBg[1] == syncBg[2]) bgStable <= syncBg[2];
      if (syncTclk[1] == syncTclk[2]) tclkLevel <= syncTclk[2];
      if (syncGate[1] == syncGate[2]) gatePinLevel <= syncGate[2];
    end
  end

  // polarity applied after the filter; result bits read from here
  logic [1:0] polResult;
  assign polResult = {result[1] ^ cmp2Ctrl[`CC_POL_BIT],
                      result[0] ^ cmp1Ctrl[`CC_POL_BIT]};

  // --------------------------------------------------------------------
  // pin output paths
  // --------------------------------------------------------------------
  // raw result bypasses the synchroniser, so pin has no added delay
  // pin mux selects result
  always_comb begin
    cmp1Pin.level  = cmp1Raw ^ cmp1Ctrl[`CC_POL_BIT];
    cmp2Pin.level  = cmp2Raw ^ cmp2Ctrl[`CC_POL_BIT];
    cmp1Pin.enable = cmp1Ctrl[`CC_PINOUT_BIT] & cmp1Ctrl[`CC_ON_BIT]
                     & ~cmp1PinDirection;
    cmp2Pin.enable = cmp2Ctrl[`CC_PINOUT_BIT] & cmp2Ctrl[`CC_ON_BIT]
                     & ~cmp2PinDirection;
  end

  // --------------------------------------------------------------------
  // timer gate
  // --------------------------------------------------------------------
  logic tclkFall;
  logic tclkRise;
  assign tclkFall = tclkPrev & ~tclkLevel;
  assign tclkRise = ~tclkPrev & tclkLevel;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tclkPrev    <= 1'b0;
      cmp2Latched <= 1'b0;
    end else begin
      tclkPrev <= tclkLevel;
      if (tclkFall) cmp2Latched <= polResult[1];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerGate <= 1'b0;
    end else if (gateCtrl[`MG_GATE_SEL_BIT]) begin
      timerGate <= gatePinLevel;
    end else begin
      timerGate <= gateCtrl[`MG_SYNC_BIT] ? cmp2Latched : polResult[1];
    end
  end

  // count strobe on the rising edge, half a timer period from capture
  // increment on rising edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) timerCountEnable <= 1'b0;
    else         timerCountEnable <= tclkRise;
  end

  // --------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------
  logic wrFire;
  logic rdFire;
  logic [7:0] wrAddr;
  assign awready = (busState == BUS_IDLE) & ~awTaken;
  assign wready  = (busState == BUS_IDLE) & ~wTaken;
  assign arready = (busState == BUS_IDLE) & ~awTaken & ~wTaken
                   & ~awvalid & ~wvalid;
  assign wrFire  = (busState == BUS_IDLE)
                   & (awTaken | awvalid) & (wTaken | wvalid);
  assign rdFire  = arready & arvalid;
  assign wrAddr  = awTaken ? awLatch : awaddr;

  // data of the write that completes this cycle
  logic [7:0] wrData;
  logic       wrLane;
  assign wrData = wTaken ? wLatch : wdata[7:0];
  assign wrLane = wTaken ? wLaneOk : wstrb[0];

  // write side may arrive split; each half is held until both exist
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awTaken <= 1'b0;
      wTaken  <= 1'b0;
      awLatch <= 8'h00;
      wLatch  <= 8'h00;
      wLaneOk <= 1'b0;
    end else if (wrFire) begin
      awTaken <= 1'b0;
      wTaken  <= 1'b0;
    end else begin
      if (awready & awvalid) begin
        awTaken <= 1'b1;
        awLatch <= awaddr;
      end
      if (wready & wvalid) begin
        wTaken  <= 1'b1;
        wLatch  <= wdata[7:0];
        wLaneOk <= wstrb[0];
      end
    end
  end

  // address decode of completed writes and accepted reads
  logic wrHit;
  logic rdHit;
  always_comb begin
    wrHit = 1'b0;
    case (wrAddr)
      `CMP1_CTRL_OFS, `CMP2_CTRL_OFS, `MIRROR_GATE_OFS,
      `LADDER_CTRL_OFS, `BANDGAP_CTRL_OFS, `FLAG_OFS,
      `IRQ_EN_OFS: wrHit = 1'b1;
      default:     wrHit = 1'b0;
    endcase
    rdHit = 1'b0;
    case (araddr)
      `CMP1_CTRL_OFS, `CMP2_CTRL_OFS, `MIRROR_GATE_OFS,
      `LADDER_CTRL_OFS, `BANDGAP_CTRL_OFS, `FLAG_OFS,
      `IRQ_EN_OFS: rdHit = 1'b1;
      default:     rdHit = 1'b0;
    endcase
  end

  // bus state and response; unmapped address answers slverr
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busState <= BUS_IDLE;
      bvalid   <= 1'b0;
      bresp    <= 2'h0;
      rvalid   <= 1'b0;
      rresp    <= 2'h0;
    end else begin
      case (busState)
        BUS_IDLE: begin
          if (wrFire) begin
            busState <= BUS_WRESP;
            bvalid   <= 1'b1;
            bresp    <= wrHit ? 2'h0 : 2'h2;
          end else if (rdFire) begin
            busState <= BUS_RRESP;
            rvalid   <= 1'b1;
            rresp    <= rdHit ? 2'h0 : 2'h2;
          end
        end
        BUS_WRESP: begin
          if (bready) begin
            bvalid   <= 1'b0;
            busState <= BUS_IDLE;
          end
        end
        BUS_RRESP: begin
          if (rready) begin
            rvalid   <= 1'b0;
            busState <= BUS_IDLE;
          end
        end
        default: busState <= BUS_IDLE;
      endcase
    end
  end

  // write strobes for each register, low byte lane only
  logic wrOk;
  assign wrOk = wrFire & wrHit & wrLane;

  // --------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------
  // reset to documented values
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp1Ctrl    <= `CMP_CTRL_RESET;
      cmp2Ctrl    <= `CMP_CTRL_RESET;
      gateCtrl    <= 2'(`MIRROR_GATE_RESET);
      ladderCtrl  <= `LADDER_RESET;
      bandgapCtrl <= `BANDGAP_RESET;
      irqEnable   <= 8'h00;
    end else if (wrOk) begin
      case (wrAddr)
        `CMP1_CTRL_OFS:    cmp1Ctrl    <= wrData & `CMP_CTRL_WMASK;
        `CMP2_CTRL_OFS:    cmp2Ctrl    <= wrData & `CMP_CTRL_WMASK;
        `MIRROR_GATE_OFS:  gateCtrl    <= wrData[1:0];
        `LADDER_CTRL_OFS:  ladderCtrl  <= wrData & `LADDER_WMASK;
        `BANDGAP_CTRL_OFS: bandgapCtrl <= wrData & `BANDGAP_WMASK;
        `IRQ_EN_OFS:       irqEnable   <= wrData & `IRQ_EN_WMASK;
        default:           irqEnable   <= irqEnable;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // mismatch store and change flags
  // --------------------------------------------------------------------
  // any read or low-lane write of a comparator's own control register refreshes its store
  // refresh on control access
  logic [1:0] refresh;
  assign refresh[0] = (wrOk & (wrAddr == `CMP1_CTRL_OFS))
                      | (rdFire & (araddr == `CMP1_CTRL_OFS));
  assign refresh[1] = (wrOk & (wrAddr == `CMP2_CTRL_OFS))
                      | (rdFire & (araddr == `CMP2_CTRL_OFS));

  // flag set on the edge into mismatch; store keeps old value otherwise
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      logic differ;
      logic differPrev;
      logic swWrite;
      logic swValue;
      assign differ  = polResult[ch] ^ mismatch[ch];
      assign swWrite = wrOk & (wrAddr == `FLAG_OFS);
      assign swValue = (ch == 0) ? wrData[`FLAG_CMP1_BIT]
                                 : wrData[`FLAG_CMP2_BIT];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mismatch[ch] <= 1'b0;
          differPrev   <= 1'b0;
        end else if (refresh[ch]) begin
          mismatch[ch] <= polResult[ch];
          differPrev   <= 1'b0;
        end else begin
          differPrev <= differ;
        end
      end
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          changeFlag[ch] <= 1'b0;
        end else if (differ & ~differPrev & ~refresh[ch]) begin
          changeFlag[ch] <= 1'b1;
        end else if (swWrite) begin
          changeFlag[ch] <= swValue;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpIrq <= 2'h0;
    end else begin
      cmpIrq[0] <= changeFlag[0] & irqEnable[`IE_CMP1_BIT]
                   & irqEnable[`IE_PERIPH_BIT] & irqEnable[`IE_GLOBAL_BIT];
      cmpIrq[1] <= changeFlag[1] & irqEnable[`IE_CMP2_BIT]
                   & irqEnable[`IE_PERIPH_BIT] & irqEnable[`IE_GLOBAL_BIT];
    end
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  // mirror of both results
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (araddr)
      `CMP1_CTRL_OFS:    rdByte = {cmp1Ctrl[7], polResult[0], cmp1Ctrl[5:0]};
      `CMP2_CTRL_OFS:    rdByte = {cmp2Ctrl[7], polResult[1], cmp2Ctrl[5:0]};
      `MIRROR_GATE_OFS:  rdByte = {polResult[0], polResult[1], 4'h0,
                                   gateCtrl};
      `LADDER_CTRL_OFS:  rdByte = ladderCtrl;
      `BANDGAP_CTRL_OFS: rdByte = bandgapCtrl
                                  | {2'h0, bgStable, 5'h00};
      `FLAG_OFS:         rdByte = {3'h0, changeFlag[1], changeFlag[0], 3'h0};
      `IRQ_EN_OFS:       rdByte = irqEnable;
      default:           rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)     rdata <= 32'h00000000;
    else if (rdFire) rdata <= {24'h000000, rdByte};
  end

  // --------------------------------------------------------------------
  // analog controls
  // --------------------------------------------------------------------
  // level field and range bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analogCtrl <= '0;
    end else begin
      analogCtrl.ladderPower    <= ladderCtrl[`LC_ROUTE1_BIT]
                                   | ladderCtrl[`LC_ROUTE2_BIT]
                                   | bandgapCtrl[`BG_LADDER_PIN_BIT];
      analogCtrl.ladderLevel    <= ladderCtrl[3:0];
      analogCtrl.ladderRangeSel <= ladderCtrl[`LC_RANGE_BIT];
      analogCtrl.ladderToPin    <= bandgapCtrl[`BG_LADDER_PIN_BIT];
      analogCtrl.fixedRefToPin  <= bandgapCtrl[`BG_PIN_BIT]
                                   & ~bandgapCtrl[`BG_LADDER_PIN_BIT];
      analogCtrl.fixedRefEnable <= bandgapCtrl[`BG_ENABLE_BIT];
      analogCtrl.bufferPower    <= ~bandgapCtrl[`BG_BYPASS_BIT];
    end
  end

endmodule
`default_nettype wire

// [src/cmp_ref_regs.svh]
// Purpose: register offsets, field positions and reset values
// Assumes: AXI4-Lite, 32-bit words, one register per aligned word
// Notes:   definitions only
`ifndef CMP_REF_REGS_SVH
`define CMP_REF_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CMP1_CTRL_OFS      8'h00
`define CMP2_CTRL_OFS      8'h04
`define MIRROR_GATE_OFS    8'h08
`define LADDER_CTRL_OFS    8'h0c
`define BANDGAP_CTRL_OFS   8'h10
`define FLAG_OFS           8'h14
`define IRQ_EN_OFS         8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CC_ON_BIT          7
`define CC_RESULT_BIT      6
`define CC_PINOUT_BIT      5
`define CC_POL_BIT         4
`define MG_MIRROR1_BIT     7
`define MG_MIRROR2_BIT     6
`define MG_GATE_SEL_BIT    1
`define MG_SYNC_BIT        0
`define LC_ROUTE1_BIT      7
`define LC_ROUTE2_BIT      6
`define LC_RANGE_BIT       5
`define BG_STABLE_BIT      5
`define BG_BYPASS_BIT      4
`define BG_ENABLE_BIT      3
`define BG_PIN_BIT         2
`define BG_LADDER_PIN_BIT  1
`define FLAG_CMP2_BIT      4
`define FLAG_CMP1_BIT      3
`define IE_CMP2_BIT        4
`define IE_CMP1_BIT        3
`define IE_PERIPH_BIT      1
`define IE_GLOBAL_BIT      0

// ----------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------
`define CMP_CTRL_RESET     8'h00
`define CMP_CTRL_WMASK     8'hbf
`define MIRROR_GATE_RESET  8'h02
`define LADDER_RESET       8'h00
`define LADDER_WMASK       8'hef
`define BANDGAP_RESET      8'h00
`define BANDGAP_WMASK      8'h1e
`define IRQ_EN_WMASK       8'h1b

`endif

// [src/cmp_ref_pkg.sv]
// Purpose: shared types of the comparator and reference control
// Assumes: nothing
// Notes:   constants live in cmp_ref_regs.svh
package cmp_ref_pkg;

  // analog controls handed to the comparator and reference cells
  typedef struct packed {
    logic       ladderPower;
    logic [3:0] ladderLevel;
    logic       ladderRangeSel;
    logic       ladderToPin;
    logic       fixedRefToPin;
    logic       fixedRefEnable;
    logic       bufferPower;
  } analog_ctrl_type;

  // per-pin output path
  typedef struct packed {
    logic level;
    logic enable;
  } pin_drive_type;

  // bus slave states
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRESP = 3'b010,
    BUS_RRESP = 3'b100
  } bus_state_type;

endpackage

// [tb/comparator_output_and_reference_ctrl_assertions.sv]
// Purpose: port checks of the comparator and reference control
// Assumes: one clock domain, bound to the design top
// Notes:   timer clock must stay slower than two bus cycles
`timescale 1ns/1ps
`default_nettype none
module comparator_output_and_reference_ctrl_assertions
  import cmp_ref_pkg::*;
(
  // clock and reset
  input wire logic            clk,
  input wire logic            resetn,
  // bus
  input wire logic            awready,
  input wire logic            arready,
  input wire logic            bvalid,
  input wire logic            bready,
  input wire logic            rvalid,
  input wire logic            rready,
  input wire logic [31:0]     rdata,
  // pins and controls
  input wire logic            cmp1PinDirection,
  input wire logic            cmp2PinDirection,
  input wire pin_drive_type   cmp1Pin,
  input wire pin_drive_type   cmp2Pin,
  input wire logic            timerCountEnable,
  input wire logic [1:0]      cmpIrq,
  input wire analog_ctrl_type analogCtrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pin_enable_one_a: assert property (
    cmp1Pin.enable |-> !cmp1PinDirection) else $error("pin 1 driven");
  pin_enable_two_a: assert property (
    cmp2Pin.enable |-> !cmp2PinDirection) else $error("pin 2 driven");
  count_pulse_single_a: assert property (
    timerCountEnable |=> !timerCountEnable) else $error("long pulse");
  reset_clear_a: assert property (
    $rose(resetn) |-> analogCtrl == '0 && cmpIrq == 2'b00)
    else $error("outputs not cleared");
  ladder_power_a: assert property (
    analogCtrl.ladderToPin |-> analogCtrl.ladderPower)
    else $error("ladder unpowered");
  pin_override_a: assert property (
    analogCtrl.ladderToPin |-> !analogCtrl.fixedRefToPin)
    else $error("fixed reference on pin");
  wresp_hold_a: assert property (
    bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  read_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  busy_refuse_a: assert property (
    bvalid |-> !awready && !arready) else $error("ready while busy");
  read_upper_a: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("upper bits set");
  cover property (bvalid && bready);
  cover property (cmpIrq[0]);
  cover property (timerCountEnable);
  cover property (cmp1Pin.enable);
endmodule
bind comparator_output_and_reference_ctrl
  comparator_output_and_reference_ctrl_assertions u_chk (.*);
`default_nettype wire

// [tb/comparator_output_and_reference_ctrl_bench.sv]
// Purpose: self-checking bench of the comparator and reference control
// Assumes: bus answers are awaited, a cycle ceiling ends a hang
// Notes:   async inputs need about four cycles to show
`timescale 1ns/1ps
`default_nettype none
module comparator_output_and_reference_ctrl_bench
  import cmp_ref_pkg::*;
;
  logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, cmp1Raw = 0, cmp2Raw = 0;
  logic bandgapReady = 0, cmp1PinDirection = 0, cmp2PinDirection = 1;
  logic timerClockIn = 0, timerGatePin = 0;
  logic [7:0] awaddr = 0, araddr = 0, lad, bg;
  logic [31:0] wdata = 0, d;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, timerGate;
  logic timerCountEnable;
  logic [1:0] bresp, rresp, r, cmpIrq;
  logic [31:0] rdata;
  pin_drive_type cmp1Pin, cmp2Pin;
  analog_ctrl_type analogCtrl;
  int badCount = 0, compares = 0, cycles = 0, pulses = 0;
  always #5 clk = ~clk;
  comparator_output_and_reference_ctrl u_comparator_output_and_reference_ctrl (.*);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // hang guard and pulse counting
  always @(posedge clk) begin
    cycles++;
    if (timerCountEnable === 1'b1) pulses++;
    if (cycles == 30000) begin
      badCount++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sampled at the falling edge, acted on at the next rising edge
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
    logic hitA, hitW;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge clk);
      hitA = awvalid & awready;
      hitW = wvalid & wready;
      @(posedge clk);
      if (hitA) awvalid <= 0;
      if (hitW) wvalid <= 0;
    end while (!(hitA && hitW) && (awvalid || wvalid) !== 1'b0);
    while (bvalid !== 1'b1) @(negedge clk);
    @(posedge clk) bready <= 0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] v,
                         output logic [1:0] rs);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk) arvalid <= 0;
    do @(negedge clk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    @(posedge clk) rready <= 0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axiRead(a, v, rs);
    check(v, e);
  endtask
  // expected analog controls from the two register values
  function automatic analog_ctrl_type expAnalog(input logic [7:0] l, b);
    analog_ctrl_type e;
    e.ladderPower = l[7] | l[6] | b[1];
    e.ladderLevel = l[3:0];
    e.ladderRangeSel = l[5];
    e.ladderToPin = b[1];
    e.fixedRefToPin = b[2] & ~b[1];
    e.fixedRefEnable = b[3];
    e.bufferPower = ~b[4];
    return e;
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(67));
    waitCyc(10);
    resetn <= 1;
    for (int i = 0; i < 7; i++) rdChk(8'(i * 4), (i == 2) ? 32'h2 : 32'h0);
    axiRead(8'h1c, d, r);
    check({30'h0, r}, 32'h2);
    check(d, 32'h0);
    // ladder and bandgap fields, first pass is ground level
    // reads come long after enable, reference settled
    @(posedge clk) bandgapReady <= 1;
    for (int i = 0; i < 8; i++) begin
      lad = (i == 0) ? 8'h20 : 8'($urandom) & 8'hef;
      bg = (i == 0) ? 8'h00 : 8'($urandom) & 8'h1e;
      axiWrite(8'h0c, {24'h0, lad});
      axiWrite(8'h10, {24'h0, bg | 8'h20});
      rdChk(8'h0c, {24'h0, lad});
      rdChk(8'h10, {24'h0, bg | 8'h20});
      check({22'h0, analogCtrl}, {22'h0, expAnalog(lad, bg)});
    end
    axiWrite(8'h00, 32'h80);
    @(posedge clk) cmp1Raw <= 1;
    waitCyc(8);
    rdChk(8'h14, 32'h08);
    rdChk(8'h08, 32'h82);
    axiWrite(8'h14, 32'h0);
    @(posedge clk) cmp1Raw <= 0;
    waitCyc(8);
    rdChk(8'h14, 32'h0);
    @(posedge clk) cmp1Raw <= 1;
    waitCyc(8);
    rdChk(8'h14, 32'h08);
    rdChk(8'h00, 32'hc0);
    axiWrite(8'h14, 32'h0);
    @(posedge clk) cmp1Raw <= 0;
    waitCyc(8);
    rdChk(8'h14, 32'h08);
    axiWrite(8'h14, 32'h0);
    rdChk(8'h08, 32'h02);
    @(posedge clk) cmp1Raw <= 1;
    waitCyc(8);
    rdChk(8'h14, 32'h0);
    // flag set by software; request waits for the global enable
    axiWrite(8'h18, 32'h0a);
    axiWrite(8'h14, 32'h08);
    waitCyc(3);
    check(32'(cmpIrq), 32'h0);
    axiWrite(8'h18, 32'h0b);
    waitCyc(3);
    check(32'(cmpIrq), 32'h1);
    axiWrite(8'h14, 32'h0);
    waitCyc(3);
    check(32'(cmpIrq), 32'h0);
    // raw result on pin, direction gates driver
    for (int i = 0; i < 4; i++) begin
      axiWrite(8'h00, 32'ha0 | (32'(i & 1) << 4));
      @(posedge clk) cmp1Raw <= 1'($urandom);
      cmp1PinDirection <= i[1];
      @(negedge clk);
      check({30'h0, cmp1Pin}, {30'h0, cmp1Raw ^ i[0], ~i[1]});
    end
    // one count pulse per timer rise
    pulses = 0;
    repeat (3) begin
      @(posedge clk) timerClockIn <= 1;
      waitCyc(4);
      timerClockIn <= 0;
      waitCyc(4);
    end
    check(32'(pulses), 32'h3);
    // synced result waits for the timer fall
    axiWrite(8'h04, 32'h80);
    // sync set while comparator 2 gates the timer
    axiWrite(8'h08, 32'h01);
    @(posedge clk) timerClockIn <= 1;
    waitCyc(6);
    cmp2Raw <= 1;
    waitCyc(8);
    check(32'(timerGate), 32'h0);
    check({30'h0, cmp2Pin}, {30'h0, cmp2Raw, 1'b0});
    timerClockIn <= 0;
    waitCyc(8);
    check(32'(timerGate), 32'h1);
    axiWrite(8'h08, 32'h00);
    @(posedge clk) cmp2Raw <= 0;
    waitCyc(8);
    check(32'(timerGate), 32'h0);
    axiWrite(8'h08, 32'h02);
    @(posedge clk) timerGatePin <= 1;
    waitCyc(6);
    check(32'(timerGate), 32'h1);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
